// [include/chs_pkg.sv]
// ****************************************************************
// Channel start / hop sync constants and state types
// ****************************************************************
package chs_pkg;

   localparam int unsigned CHS_NUM_CH = 4;

   // ****************************************************************
   // External (chip level) register offsets
   // ****************************************************************
   localparam logic [7:0] CHS_EXT_SLEEP = 8'h03;
   localparam logic [7:0] CHS_EXT_PIN_CTRL = 8'h04;
   localparam logic [7:0] CHS_EXT_SOFT_CTRL = 8'h05;

   // ****************************************************************
   // Per-channel register offsets
   // ****************************************************************
   localparam logic [7:0] CHS_CH_SOFT_MIRROR = 8'h81;
   localparam logic [7:0] CHS_CH_PIN_MIRROR = 8'h82;
   localparam logic [7:0] CHS_CH_START_PRE = 8'h83;
   localparam logic [7:0] CHS_CH_HOP_PRE = 8'h84;
   localparam logic [7:0] CHS_CH_FREQ_LO = 8'h85;
   localparam logic [7:0] CHS_CH_FREQ_HI = 8'h86;
   localparam logic [7:0] CHS_CH_IN_SEL = 8'h88;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned CHS_SOFT_START_BIT = 4;
   localparam int unsigned CHS_SOFT_HOP_BIT = 5;
   localparam int unsigned CHS_PIN_START_EN_BIT = 4;
   localparam int unsigned CHS_PIN_HOP_EN_BIT = 5;
   localparam int unsigned CHS_PIN_FIRST_ONLY_BIT = 6;
   localparam int unsigned CHS_IN_SEL_LSB = 7;

   // ****************************************************************
   // Extra cycles added to the preload, per trigger source
   // ****************************************************************
   localparam logic [3:0] CHS_START_SOFT_EXTRA = 4'h7;
   localparam logic [3:0] CHS_START_PIN_EXTRA = 4'h3;
   localparam logic [3:0] CHS_HOP_SOFT_EXTRA = 4'h8;
   localparam logic [3:0] CHS_HOP_PIN_EXTRA = 4'h5;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0] CHS_SLEEP_RST = 4'hf;
   localparam logic [16:0] CHS_CNT_RST = 17'h00000;

   // ****************************************************************
   // State types
   // ****************************************************************
   typedef struct packed {
      logic [3:0] sleep;
      logic [7:0] pin_ctrl;
      logic [7:0] soft_ctrl;
      logic [3:0][1:0] soft_mir;
      logic [3:0][2:0] pin_mir;
      logic [3:0][15:0] start_pre;
      logic [3:0][15:0] hop_pre;
      logic [3:0][15:0] freq_lo;
      logic [3:0][15:0] freq_hi;
      logic [3:0][1:0] in_sel;
      logic [3:0][31:0] nco_work;
      logic [15:0] rdata;
      logic ack_n;
   } chs_core_s;

   typedef struct packed {
      logic [3:0] pin_prev;
      logic taken;
   } chs_pin_s;

   localparam chs_core_s CHS_CORE_RST = '{sleep: CHS_SLEEP_RST, ack_n: 1'b1, default: '0};
   localparam chs_pin_s CHS_PIN_RST = '{default: '0};

endpackage

// [src/chs_holdoff.sv]
`timescale 1ns/100ps
// ****************************************************************
// Hold-off counter: loads preload plus source latency, fires at one
// ****************************************************************
module chs_holdoff
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_trig,
   input wire logic [15:0] i_preload,
   input wire logic [3:0] i_extra,
   output logic o_fire
);
   import chs_pkg::*;

   logic [16:0] cnt_q;
   logic [16:0] cnt_d;

   // Reload on every trigger, even mid-count; zero preload cancels
   always_comb
   begin
      cnt_d = cnt_q;
      if (i_trig)
      begin
         if (i_preload != 16'h0000)
            cnt_d = {1'b0, i_preload} + {13'h0000, i_extra};
         else
            cnt_d = CHS_CNT_RST;
      end
      else if (cnt_q != CHS_CNT_RST)
         cnt_d = cnt_q - 17'h00001;
   end

   // Counter register
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt_q <= CHS_CNT_RST;
      else
         cnt_q <= cnt_d;
   end

   assign o_fire = (cnt_q == 17'h00001);

endmodule // chs_holdoff

// [src/chs_pin_trig.sv]
`timescale 1ns/100ps
// ****************************************************************
// Per-channel pin trigger selection and first-trigger-only gate
// ****************************************************************
module chs_pin_trig
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_pins,
   input wire logic [3:0] i_pin_en,
   input wire logic [1:0] i_sel,
   input wire logic i_start_en,
   input wire logic i_hop_en,
   input wire logic i_first_only,
   output logic o_start_trig,
   output logic o_hop_trig
);
   import chs_pkg::*;

   chs_pin_s q;
   chs_pin_s d;
   logic rise;
   logic accept;

   // A high level after a low sample is one trigger event
   always_comb
   begin
      d = q;
      d.pin_prev = i_pins;
      rise = i_pins[i_sel] & ~q.pin_prev[i_sel] & i_pin_en[i_sel];
      accept = rise & ~(i_first_only & q.taken);
      // Latch stays set until software drops the first-only bit
      if (!i_first_only)
         d.taken = 1'b0;
      else if (accept & (i_start_en | i_hop_en))
         d.taken = 1'b1;
      o_start_trig = accept & i_start_en;
      o_hop_trig = accept & i_hop_en;
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         q <= CHS_PIN_RST;
      else
         q <= d;
   end

endmodule // chs_pin_trig

// [src/chs_sync_ctrl.sv]
`timescale 1ns/100ps
// Contract
// - Start counter holds 16-bit preload, counts clocks
// - Zero start preload keeps channel asleep
// - Start bit plus selects starts counters
// - Count of one clears sleep bit
// - Per-channel soft mirror register triggers channel
// - Soft start delay is preload plus six (code adds seven)
// - Start-on-pin bit and per-pin enables gate
// - Input select bits pick pin A to D
// - Selected pin high starts counters, wakes channel
// - First-only bit blocks later pin triggers
// - Per-channel pin mirror register controls channel
// - Pin start delay is preload plus three
// - Clearing sleep issues internal start and hop
// - Hop bit plus selects starts hop counters
// - Shadow frequency moves to NCO at one
// - Hop works while channel is awake
// - Soft hop delay is preload plus seven (code adds eight)
// - Hop-on-pin with pin enable starts countdown
// - Pin hop delay is preload plus five
// - Reset puts all four channels asleep
// ****************************************************************
// Start and hop synchronisation for the four channels
// ****************************************************************
module chs_sync_ctrl
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_chan_space,
   input wire logic [1:0] i_chan,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [3:0] i_sync_pins,
   output logic [15:0] o_rdata,
   output logic o_bus_transfer_ack_n,
   output logic [3:0] o_chan_sleep,
   output logic [127:0] o_nco_freq
);
   import chs_pkg::*;

   // Register state and its next value
   chs_core_s q;
   chs_core_s d;
   // Access decode
   logic ext_wr;
   logic chan_wr;
   logic any_access;
   // Per-channel trigger strobes and counter outputs
   logic [3:0] start_soft;
   logic [3:0] hop_soft;
   logic [3:0] start_pin;
   logic [3:0] hop_pin;
   logic [3:0] start_trig;
   logic [3:0] hop_trig;
   logic [3:0] start_fire;
   logic [3:0] hop_fire;
   // Latency added to the preload, chosen per trigger source
   logic [3:0][3:0] start_extra;
   logic [3:0][3:0] hop_extra;

   // ****************************************************************
   // Access decode
   // ****************************************************************
   // Space bit picks the map; either strobe earns an acknowledge
   assign ext_wr = i_wr & ~i_chan_space;
   assign chan_wr = i_wr & i_chan_space;
   assign any_access = i_wr | i_rd;

   // ****************************************************************
   // Per-channel trigger paths and hold-off counters
   // ****************************************************************
   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_chan
         // Pin routing per channel, gated by its own mirror bits
         chs_pin_trig u_pin
         (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_pins(i_sync_pins),
            .i_pin_en(q.pin_ctrl[3:0]),
            .i_sel(q.in_sel[g]),
            .i_start_en(q.pin_mir[g][0]),
            .i_hop_en(q.pin_mir[g][1]),
            .i_first_only(q.pin_mir[g][2]),
            .o_start_trig(start_pin[g]),
            .o_hop_trig(hop_pin[g])
         );

         // Soft source wins the latency choice when both arrive together
         assign start_trig[g] = start_soft[g] | start_pin[g];
         assign hop_trig[g] = hop_soft[g] | hop_pin[g];
         assign start_extra[g] = start_soft[g] ? CHS_START_SOFT_EXTRA : CHS_START_PIN_EXTRA;
         assign hop_extra[g] = hop_soft[g] ? CHS_HOP_SOFT_EXTRA : CHS_HOP_PIN_EXTRA;

         // Start hold-off
         chs_holdoff u_start
         (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_trig(start_trig[g]),
            .i_preload(q.start_pre[g]),
            .i_extra(start_extra[g]),
            .o_fire(start_fire[g])
         );

         // Frequency hold-off
         chs_holdoff u_hop
         (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_trig(hop_trig[g]),
            .i_preload(q.hop_pre[g]),
            .i_extra(hop_extra[g]),
            .o_fire(hop_fire[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Register writes, soft triggers, wake and hop updates, reads
   // ****************************************************************
   always_comb
   begin
      d = q;
      d.ack_n = 1'b1;
      start_soft = 4'h0;
      hop_soft = 4'h0;

      // External register space
      if (ext_wr)
      begin
         case (i_addr)
            CHS_EXT_SLEEP:
            begin
               // Sleep request is immediate; a wake waits for the start count
               for (int c = 0; c < 4; c++)
               begin
                  if (q.sleep[c] && !i_wdata[c])
                  begin
                     start_soft[c] = 1'b1;
                     hop_soft[c] = 1'b1;
                  end
               end
               // Ones sleep at once; zeros on sleeping channels only arm a start and a hop
               d.sleep = q.sleep | i_wdata[3:0];
            end
            CHS_EXT_PIN_CTRL:
            begin
               d.pin_ctrl = i_wdata[7:0];
               // Global write overwrites every channel's pin mirror
               for (int c = 0; c < 4; c++)
               begin
                  d.pin_mir[c] = i_wdata[CHS_PIN_FIRST_ONLY_BIT:CHS_PIN_START_EN_BIT];
               end
            end
            CHS_EXT_SOFT_CTRL:
            begin
               d.soft_ctrl = i_wdata[7:0];
               // Only selected channels copy the trigger bits
               for (int c = 0; c < 4; c++)
               begin
                  if (i_wdata[c])
                  begin
                     d.soft_mir[c] = i_wdata[CHS_SOFT_HOP_BIT:CHS_SOFT_START_BIT];
                     start_soft[c] = i_wdata[CHS_SOFT_START_BIT];
                     hop_soft[c] = i_wdata[CHS_SOFT_HOP_BIT];
                  end
               end
            end
            default:
            begin
               // Other external offsets ignore the write
            end
         endcase
      end

      // Channel register space
      if (chan_wr)
      begin
         case (i_addr)
            CHS_CH_SOFT_MIRROR:
            begin
               // A mirror write triggers only the addressed channel
               d.soft_mir[i_chan] = i_wdata[CHS_SOFT_HOP_BIT:CHS_SOFT_START_BIT];
               start_soft[i_chan] = i_wdata[CHS_SOFT_START_BIT];
               hop_soft[i_chan] = i_wdata[CHS_SOFT_HOP_BIT];
            end
            CHS_CH_PIN_MIRROR:
            begin
               d.pin_mir[i_chan] = i_wdata[CHS_PIN_FIRST_ONLY_BIT:CHS_PIN_START_EN_BIT];
            end
            CHS_CH_START_PRE:
            begin
               d.start_pre[i_chan] = i_wdata;
            end
            CHS_CH_HOP_PRE:
            begin
               d.hop_pre[i_chan] = i_wdata;
            end
            CHS_CH_FREQ_LO:
            begin
               d.freq_lo[i_chan] = i_wdata;
            end
            CHS_CH_FREQ_HI:
            begin
               d.freq_hi[i_chan] = i_wdata;
            end
            CHS_CH_IN_SEL:
            begin
               d.in_sel[i_chan] = i_wdata[CHS_IN_SEL_LSB+1:CHS_IN_SEL_LSB];
            end
            default:
            begin
               // Other channel offsets ignore the write
            end
         endcase
      end

      // Counter events override a same-cycle sleep write; hop ignores sleep
      for (int c = 0; c < 4; c++)
      begin
         if (start_fire[c])
         begin
            d.sleep[c] = 1'b0;
         end
         if (hop_fire[c])
         begin
            d.nco_work[c] = {q.freq_hi[c], q.freq_lo[c]};
         end
      end

      // Read mux; unmapped offsets read zero
      if (i_rd)
      begin
         d.rdata = 16'h0000;
         if (!i_chan_space)
         begin
            case (i_addr)
               CHS_EXT_SLEEP:
                  d.rdata = {12'h000, q.sleep};
               CHS_EXT_PIN_CTRL:
                  d.rdata = {8'h00, q.pin_ctrl};
               CHS_EXT_SOFT_CTRL:
                  d.rdata = {8'h00, q.soft_ctrl};
               default:
                  d.rdata = 16'h0000;
            endcase
         end
         else
         begin
            // Mirror fields read back at their write positions
            case (i_addr)
               CHS_CH_SOFT_MIRROR:
                  d.rdata = {10'h000, q.soft_mir[i_chan], 4'h0};
               CHS_CH_PIN_MIRROR:
                  d.rdata = {9'h000, q.pin_mir[i_chan], 4'h0};
               CHS_CH_START_PRE:
                  d.rdata = q.start_pre[i_chan];
               CHS_CH_HOP_PRE:
                  d.rdata = q.hop_pre[i_chan];
               CHS_CH_FREQ_LO:
                  d.rdata = q.freq_lo[i_chan];
               CHS_CH_FREQ_HI:
                  d.rdata = q.freq_hi[i_chan];
               CHS_CH_IN_SEL:
                  d.rdata = {7'h00, q.in_sel[i_chan], 7'h00};
               default:
                  d.rdata = 16'h0000;
            endcase
         end
      end

      // One-cycle low acknowledge for every access
      if (any_access)
      begin
         d.ack_n = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Reset leaves every channel asleep
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         q <= CHS_CORE_RST;
      else
         q <= d;
   end

   // ****************************************************************
   // Outputs, all straight from the state register
   // ****************************************************************
   assign o_rdata = q.rdata;
   assign o_bus_transfer_ack_n = q.ack_n;
   assign o_chan_sleep = q.sleep;
   assign o_nco_freq = q.nco_work;

endmodule // chs_sync_ctrl

// [verification/chs_pulse_src.sv]
`timescale 1ns/100ps
// ****************************************************************
// External sync pulse source driving the trigger pins
// ****************************************************************
module chs_pulse_src
(
   input wire logic i_core_clk,
   input wire logic [3:0] i_req,
   output logic [3:0] o_pins
);
   initial o_pins = 4'h0;
   // Registered, so pins move just after an edge like a real driver
   always @(posedge i_core_clk)
      o_pins <= i_req;
endmodule // chs_pulse_src

// [verification/chs_sync_ctrl_checker.sv]
`timescale 1ns/100ps
// ****************************************************************
// Port checks: bus handshake, reset state, sleep control
// ****************************************************************
module chs_sync_ctrl_checker
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_chan_space,
   input wire logic [1:0] i_chan,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [3:0] i_sync_pins,
   input wire logic [15:0] o_rdata,
   input wire logic o_bus_transfer_ack_n,
   input wire logic [3:0] o_chan_sleep,
   input wire logic [127:0] o_nco_freq
);
   import chs_pkg::*;
   // Single domain, so reset gates every check
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_ack_after_access: assert property ((i_wr || i_rd) |=> !o_bus_transfer_ack_n)
      else $error("access not acknowledged");
   a_ack_needs_access: assert property (!(i_wr || i_rd) |=> o_bus_transfer_ack_n)
      else $error("acknowledge without access");
   a_rdata_holds_idle: assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved without a read");
   a_reset_all_asleep: assert property ($rose(i_rst_n) |-> o_chan_sleep == 4'hf)
      else $error("channels awake after reset");
   a_reset_nco_clear: assert property ($rose(i_rst_n) |-> o_nco_freq == '0)
      else $error("frequency not cleared by reset");
   a_sleep_rise_cause: assert property (|(o_chan_sleep & ~$past(o_chan_sleep)) |->
      $past(i_wr && !i_chan_space && i_addr == CHS_EXT_SLEEP))
      else $error("sleep set without a sleep write");
   a_sleep_write_now: assert property (i_wr && !i_chan_space && i_addr == CHS_EXT_SLEEP |=>
      (o_chan_sleep & $past(i_wdata[3:0])) == $past(i_wdata[3:0]))
      else $error("sleep write not applied");
   a_mirror_read_bits: assert property (i_rd && !i_wr && i_chan_space &&
      i_addr == CHS_CH_SOFT_MIRROR |=> (o_rdata & 16'hffcf) == 16'h0000)
      else $error("soft mirror read shows stray bits");
endmodule // chs_sync_ctrl_checker

bind chs_sync_ctrl chs_sync_ctrl_checker u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_wr(i_wr), .i_rd(i_rd), .i_chan_space(i_chan_space), .i_chan(i_chan), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_sync_pins(i_sync_pins), .o_rdata(o_rdata),
   .o_bus_transfer_ack_n(o_bus_transfer_ack_n), .o_chan_sleep(o_chan_sleep),
   .o_nco_freq(o_nco_freq));

// [verification/test_channel_start_hop_sync.sv]
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench for start / hop synchronisation
// ****************************************************************
module test_channel_start_hop_sync;
   import chs_pkg::*;
   logic clk, rst_n, wr, rd, sp, ack;
   logic [1:0] ch;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [3:0] pins, req, sleep;
   logic [127:0] nco;
   logic [31:0] f;
   int num_errors, num_checks, p, q;
   int exp_nco[4];
   chs_sync_ctrl dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_wr(wr), .i_rd(rd),
      .i_chan_space(sp), .i_chan(ch), .i_addr(addr), .i_wdata(wdata), .i_sync_pins(pins),
      .o_rdata(rdata), .o_bus_transfer_ack_n(ack), .o_chan_sleep(sleep), .o_nco_freq(nco));
   chs_pulse_src u_src (.i_core_clk(clk), .i_req(req), .o_pins(pins));
   // 100 MHz core clock
   always #5 clk = ~clk;
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, want, seen);
      end
   endtask
   // One-cycle strobe; ack is due in the cycle after the taking edge
   task automatic acc(input bit w, input bit s, input int c, input logic [7:0] a, input int d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      sp <= s;
      ch <= c[1:0];
      addr <= a;
      wdata <= d[15:0];
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      chk("ack", ack, 1'b0);
   endtask
   // Pin high for two cycles; returns just after the edge that samples it
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      req <= m;
      repeat (2) @(posedge clk);
      req <= 4'h0;
      #1;
   endtask
   // Edges until sleep falls (k=0) or the NCO word moves (k=1); 300 means never
   task automatic lat(input bit k, input int c, input int want);
      int n;
      logic [31:0] v;
      v = nco[32*c +: 32];
      n = 0;
      while (n < 300 && (k ? nco[32*c +: 32] === v : sleep[c] !== 1'b0))
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("latency", n, want);
      if (k)
         chk("nco", nco[32*c +: 32], exp_nco[c]);
      if (n == 300 && want != 300)
         wrap_up();
   endtask
   // Counts, verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wr, rd, sp, ch, addr, wdata, req} = '0;
      void'($urandom(30666));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("sleep", sleep, 4'hf);
      p = $urandom_range(20, 1);
      acc(1, 1, 0, CHS_CH_START_PRE, p);
      acc(0, 1, 0, CHS_CH_START_PRE, 0);
      chk("start_pre", rdata, p);
      // Soft start of channels 0 to 2, channel 2 with a zero preload
      acc(1, 1, 1, CHS_CH_START_PRE, p);
      acc(1, 1, 2, CHS_CH_START_PRE, 0);
      acc(1, 0, 0, CHS_EXT_SOFT_CTRL, 'h17);
      lat(0, 0, p + 7);
      chk("ch1_awake", sleep[1], 1'b0);
      chk("ch3_asleep", sleep[3], 1'b1);
      lat(0, 2, 300);
      // Hop on a running channel, retriggered while counting
      q = $urandom_range(20, 1);
      f = $urandom;
      exp_nco[1] = f;
      acc(1, 1, 1, CHS_CH_HOP_PRE, q);
      acc(1, 1, 1, CHS_CH_FREQ_LO, f[15:0]);
      acc(1, 1, 1, CHS_CH_FREQ_HI, f[31:16]);
      chk("shadow", nco[63:32], 32'h0);
      acc(1, 1, 1, CHS_CH_SOFT_MIRROR, 'h20);
      acc(0, 1, 1, CHS_CH_SOFT_MIRROR, 0);
      chk("mirror", rdata, 16'h0020);
      acc(1, 1, 1, CHS_CH_SOFT_MIRROR, 'h20);
      lat(1, 1, q + 8);
      // Pin start through each pin, after a pulse on the disabled ones
      acc(1, 1, 3, CHS_CH_START_PRE, p);
      for (int s = 0; s < 4; s++)
      begin
         acc(1, 0, 0, CHS_EXT_SLEEP, 'h0c);
         acc(1, 1, 3, CHS_CH_IN_SEL, s << 7);
         acc(1, 0, 0, CHS_EXT_PIN_CTRL, 'h10 | (1 << s));
         pulse(4'hf ^ (4'h1 << s));
         lat(0, 3, 300);
         pulse(4'h1 << s);
         lat(0, 3, p + 3);
      end
      // Pin hop on pin D with first trigger only
      f = $urandom;
      exp_nco[3] = f;
      acc(1, 1, 3, CHS_CH_HOP_PRE, q);
      acc(1, 1, 3, CHS_CH_FREQ_LO, f[15:0]);
      acc(1, 1, 3, CHS_CH_FREQ_HI, f[31:16]);
      acc(1, 0, 0, CHS_EXT_PIN_CTRL, 'h68);
      acc(0, 0, 0, CHS_EXT_PIN_CTRL, 0);
      chk("pin_ctrl", rdata[7:0], 8'h68);
      pulse(4'h8);
      lat(1, 3, q + 5);
      acc(1, 1, 3, CHS_CH_FREQ_LO, ~f[15:0]);
      pulse(4'h8);
      lat(1, 3, 300);
      // Clearing first-only in the channel mirror lets pin D hop again
      exp_nco[3] = {f[31:16], ~f[15:0]};
      acc(1, 1, 3, CHS_CH_PIN_MIRROR, 'h20);
      acc(0, 1, 3, CHS_CH_PIN_MIRROR, 0);
      chk("pin_mirror", rdata, 16'h0020);
      pulse(4'h8);
      lat(1, 3, q + 5);
      // Waking channel 0 by its sleep bit also hops its NCO
      f = $urandom;
      exp_nco[0] = f;
      acc(1, 0, 0, CHS_EXT_SLEEP, 'h05);
      acc(1, 1, 0, CHS_CH_HOP_PRE, p + 10);
      acc(1, 1, 0, CHS_CH_FREQ_LO, f[15:0]);
      acc(1, 1, 0, CHS_CH_FREQ_HI, f[31:16]);
      acc(1, 0, 0, CHS_EXT_SLEEP, 'h04);
      lat(0, 0, p + 7);
      lat(1, 0, 11);
      wrap_up();
   end
endmodule // test_channel_start_hop_sync
